// ### design/avdr_top.sv
`timescale 1ns/100ps
module avdr_top (
  input  wire logic                        SYS_CLK_I,
  input  wire logic                        RST_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  input  wire logic [7:0]                  REG_ADDR_I,
  input  wire logic [7:0]                  REG_WDATA_I,
  output logic      [7:0]                  REG_RDATA_O,
  output logic                             REG_RVALID_O,
  input  wire logic [1:0]                  CH_FAULT_I,
  input  wire logic [1:0]                  LOAD_DONE_I,
  input  wire avdr_pkg::avdr_result_t [1:0] LOAD_RESULT_I,
  input  wire logic [1:0]                  LINE_OUT_FOUND_I,
  output logic      [1:0]                  LOAD_RUN_O,
  output logic                             LOAD_ABORT_O,
  output logic                             DOUBLE_RAMP_O,
  output logic                             DOUBLE_SETTLE_O,
  output logic                             LINE_OUT_CHECK_EN_O,
  output logic      [3:0]                  CH1_SHORT_THRESHOLD_O,
  output logic      [3:0]                  CH2_SHORT_THRESHOLD_O,
  output logic      [1:0][7:0]             GAIN_CODE_O,
  output logic      [1:0]                  MUTE_O,
  output avdr_pkg::avdr_state_t [1:0]      STATE_O
);
  import avdr_pkg::*;

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]        chreq_q, chreq_d;     // Requested states, host written
  logic [1:0][7:0]   gain_q, gain_d;       // Channel gain codes
  logic [7:0]        ctl_q, ctl_d;         // Check control
  logic [7:0]        thr_q, thr_d;         // Shorted-load thresholds
  logic [7:0]        res_q, res_d;         // Check findings
  logic [1:0]        lo_q, lo_d;           // Line-output found, per channel
  avdr_state_t [1:0] st_q, st_d;           // Actual channel states
  logic [1:0]        mute_q, mute_d;       // Registered mute flags
  logic [1:0]        run_q, run_d;         // Check running, per channel
  logic [7:0]        rdata_q, rdata_d;     // Read data
  logic              rvalid_q, rvalid_d;   // Read answer strobe

  // Decoded helpers
  avdr_state_t [1:0] req;                  // Requested state per channel
  logic [1:0]        diag_wr;              // Host asks for a check
  logic              any_diag;             // Some channel is checking
  logic              wr_ctl;               // Write to check control

  // ****************************************
  // Write decode
  // ****************************************
  // Host requests come from register 0x04
  always_comb begin
    req[0]   = avdr_state_t'(chreq_q[7:6]);
    req[1]   = avdr_state_t'(chreq_q[5:4]);
    wr_ctl   = REG_WR_I && (REG_ADDR_I == ADDR_CHECK_CTL);
    diag_wr  = 2'b00;
    if (REG_WR_I && (REG_ADDR_I == ADDR_CH_STATE)) begin
      diag_wr[0] = (REG_WDATA_I[7:6] == ST_DIAG);
      diag_wr[1] = (REG_WDATA_I[5:4] == ST_DIAG);
    end
    any_diag = (st_q[0] == ST_DIAG) || (st_q[1] == ST_DIAG);
  end

  // ****************************************
  // Host registers
  // ****************************************
  // Next values of the writable registers
  always_comb begin
    chreq_d = chreq_q;
    gain_d  = gain_q;
    thr_d   = thr_q;
    ctl_d   = ctl_q;
    // Abort is held until no channel is checking
    // A host write in the same cycle wins over this clear
    if (ctl_q[BIT_ABORT] && !any_diag) begin
      ctl_d[BIT_ABORT] = 1'b0;
    end
    if (REG_WR_I) begin
      unique case (REG_ADDR_I)
        ADDR_CH_STATE:   chreq_d   = REG_WDATA_I;
        ADDR_CH1_GAIN:   gain_d[0] = REG_WDATA_I;
        ADDR_CH2_GAIN:   gain_d[1] = REG_WDATA_I;
        ADDR_CHECK_CTL:  ctl_d     = REG_WDATA_I;
        ADDR_THRESHOLDS: thr_d     = REG_WDATA_I;
        default: begin
          // Read-only and unmapped: ignored
        end
      endcase
    end
    // Mute when the code falls below the -100 dB step
    for (int c = 0; c < 2; c++) begin
      mute_d[c] = (gain_d[c] < GAIN_MIN_CODE);
    end
  end

  // Register the host-facing state
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      chreq_q <= RST_CH_STATE;
      gain_q  <= {RST_GAIN, RST_GAIN};
      ctl_q   <= RST_CHECK_CTL;
      thr_q   <= RST_THRESHOLDS;
      mute_q  <= 2'b00;
    end else begin
      chreq_q <= chreq_d;
      gain_q  <= gain_d;
      ctl_q   <= ctl_d;
      thr_q   <= thr_d;
      mute_q  <= mute_d;
    end
  end

  // ****************************************
  // Channel state and check sequencing
  // ****************************************
  // A check ends on done or abort, then the channel
  // moves to its request; a pending check request
  // falls back to high impedance so it runs once.
  always_comb begin
    avdr_state_t tgt;
    logic        start;
    tgt   = ST_HIZ;
    start = 1'b0;
    st_d  = st_q;
    res_d = res_q;
    lo_d  = lo_q;
    for (int c = 0; c < 2; c++) begin
      tgt = (req[c] == ST_DIAG) ? ST_HIZ : req[c];
      if (st_q[c] == ST_DIAG) begin
        if (ctl_q[BIT_ABORT]) begin
          st_d[c] = tgt;
        end else if (LOAD_DONE_I[c]) begin
          // Latest run overwrites the findings
          res_d[7-4*c -: 4] = LOAD_RESULT_I[c];
          lo_d[c]  = LINE_OUT_FOUND_I[c] && ctl_q[BIT_LINE_EN];
          st_d[c]  = tgt;
        end
      end else begin
        // Auto run on leaving high impedance or fault
        start = !ctl_q[BIT_ABORT] && (diag_wr[c] || (!ctl_q[BIT_AUTO_SKIP] &&
                ((st_q[c] == ST_HIZ && tgt != ST_HIZ) || CH_FAULT_I[c])));
        st_d[c] = start ? ST_DIAG : tgt;
      end
      run_d[c] = (st_d[c] == ST_DIAG);
    end
  end

  // Register the channel side
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      st_q  <= '{ST_HIZ, ST_HIZ};
      res_q <= RST_RESULT;
      lo_q  <= 2'b00;
      run_q <= 2'b00;
    end else begin
      st_q  <= st_d;
      res_q <= res_d;
      lo_q  <= lo_d;
      run_q <= run_d;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  // Answer one cycle after the read strobe
  always_comb begin
    rvalid_d = REG_RD_I;
    rdata_d  = 8'h00;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        ADDR_CH_STATE:    rdata_d = chreq_q;
        ADDR_CH1_GAIN:    rdata_d = gain_q[0];
        ADDR_CH2_GAIN:    rdata_d = gain_q[1];
        ADDR_CHECK_CTL:   rdata_d = ctl_q;
        ADDR_THRESHOLDS:  rdata_d = thr_q;
        ADDR_RESULT:      rdata_d = res_q;
        ADDR_LINE_RESULT: rdata_d = {4'h0, lo_q[0], lo_q[1], 2'b00};
        ADDR_STATE_READ:  rdata_d = {st_q[0], st_q[1], STATE_READ_TAIL};
        default:          rdata_d = 8'h00;
      endcase
    end
  end

  // Register the read answer
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ****************************************
  // Outputs, all straight from flops
  // ****************************************
  assign REG_RDATA_O           = rdata_q;
  assign REG_RVALID_O          = rvalid_q;
  assign LOAD_RUN_O            = run_q;
  assign LOAD_ABORT_O          = ctl_q[BIT_ABORT];
  assign DOUBLE_RAMP_O         = ctl_q[BIT_DBL_RAMP];
  assign DOUBLE_SETTLE_O       = ctl_q[BIT_DBL_SETTLE];
  assign LINE_OUT_CHECK_EN_O   = ctl_q[BIT_LINE_EN];
  assign CH1_SHORT_THRESHOLD_O = thr_q[7:4];
  assign CH2_SHORT_THRESHOLD_O = thr_q[3:0];
  assign GAIN_CODE_O           = gain_q;
  assign MUTE_O                = mute_q;
  assign STATE_O               = st_q;

  // ****************************************
  // Checks
  // ****************************************
  // Auto-run cause: high impedance left, no skip
  sequence s_leave_hiz;
    !ctl_q[BIT_AUTO_SKIP] && !ctl_q[BIT_ABORT] && st_q[0] == ST_HIZ
      && req[0] == ST_PLAY && !REG_WR_I;
  endsequence

  sequence s_diag_done;
    st_q[0] == ST_DIAG && LOAD_DONE_I[0] && !ctl_q[BIT_ABORT];
  endsequence

  a_mute_low_code: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == ADDR_CH1_GAIN |=> MUTE_O[0] == ($past(REG_WDATA_I) < 8'h07))
    else $error("mute flag wrong for gain code");

  a_gain_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == ADDR_CH2_GAIN |=> GAIN_CODE_O[1] == $past(REG_WDATA_I))
    else $error("channel two gain not stored");

  a_abort_ends: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    LOAD_ABORT_O && !REG_WR_I |=> STATE_O[0] != ST_DIAG && STATE_O[1] != ST_DIAG ##1 !LOAD_ABORT_O)
    else $error("abort did not end check and clear");

  a_ramp_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    wr_ctl |=> DOUBLE_RAMP_O == $past(REG_WDATA_I[6]))
    else $error("double ramp not taken from bit 6");

  a_settle_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    wr_ctl |=> DOUBLE_SETTLE_O == $past(REG_WDATA_I[5]))
    else $error("double settle not taken from bit 5");

  a_auto_start: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_leave_hiz |=> STATE_O[0] == ST_DIAG && LOAD_RUN_O[0])
    else $error("automatic check did not start");

  a_skip_holds: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ctl_q[BIT_AUTO_SKIP] && st_q[0] == ST_HIZ && !REG_WR_I && !CH_FAULT_I[0] |=> STATE_O[0] != ST_DIAG)
    else $error("check ran while skipped");

  a_result_latch: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_diag_done |=> res_q[7:4] == $past(LOAD_RESULT_I[0]) && STATE_O[0] != ST_DIAG)
    else $error("findings not latched on done");

  a_line_read: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == ADDR_LINE_RESULT |=> REG_RVALID_O && REG_RDATA_O[7:4] == 4'h0
      && REG_RDATA_O[1:0] == 2'b00 && REG_RDATA_O[3:2] == {$past(lo_q[0]), $past(lo_q[1])})
    else $error("line-output readback wrong");

  a_state_read: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_RD_I && REG_ADDR_I == ADDR_STATE_READ |=> REG_RDATA_O == {$past(st_q[0]), $past(st_q[1]), 4'h5})
    else $error("state readback wrong");

  a_reset_state: assert property (@(posedge SYS_CLK_I)
    $past(RST_I) |-> STATE_O[0] == ST_HIZ && STATE_O[1] == ST_HIZ)
    else $error("state not high impedance after reset");

  // Thresholds land whole, channel one on top
  a_thr_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    REG_WR_I && REG_ADDR_I == ADDR_THRESHOLDS |=>
      {CH1_SHORT_THRESHOLD_O, CH2_SHORT_THRESHOLD_O} == $past(REG_WDATA_I))
    else $error("shorted-load thresholds not stored");

  // Line finding must stay clear while detection is off
  a_line_gated: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_q[0] == ST_DIAG && LOAD_DONE_I[0] && !ctl_q[BIT_ABORT] && !ctl_q[BIT_LINE_EN] |=> !lo_q[0])
    else $error("line output reported while detection off");

  // Channel two findings go to the low nibble
  a_ch2_result: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    st_q[1] == ST_DIAG && LOAD_DONE_I[1] && !ctl_q[BIT_ABORT] |=> res_q[3:0] == $past(LOAD_RESULT_I[1]))
    else $error("channel two findings not latched");

  // A pending abort keeps idle channels from starting
  a_abort_blocks: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    ctl_q[BIT_ABORT] && st_q[0] != ST_DIAG && st_q[1] != ST_DIAG
      |=> STATE_O[0] != ST_DIAG && STATE_O[1] != ST_DIAG)
    else $error("check started while abort pending");

endmodule : avdr_top

// ### design/avdr_pkg.sv
// ****************************************
// Shared constants and types
// ****************************************
package avdr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CH_STATE    = 8'h04;
  localparam logic [7:0] ADDR_CH1_GAIN    = 8'h05;
  localparam logic [7:0] ADDR_CH2_GAIN    = 8'h06;
  localparam logic [7:0] ADDR_CHECK_CTL   = 8'h09;
  localparam logic [7:0] ADDR_THRESHOLDS  = 8'h0A;
  localparam logic [7:0] ADDR_RESULT      = 8'h0C;
  localparam logic [7:0] ADDR_LINE_RESULT = 8'h0E;
  localparam logic [7:0] ADDR_STATE_READ  = 8'h0F;

  // Reset values
  localparam logic [7:0] RST_CH_STATE   = 8'h55;
  localparam logic [7:0] RST_GAIN       = 8'hCF;
  localparam logic [7:0] RST_CHECK_CTL  = 8'h00;
  localparam logic [7:0] RST_THRESHOLDS = 8'h11;
  localparam logic [7:0] RST_RESULT     = 8'h00;

  // Gain codes: 0.5 dB per step, top code +24 dB
  localparam logic [7:0] GAIN_UNITY     = 8'hCF;
  localparam logic [7:0] GAIN_MIN_CODE  = 8'h07;

  // Field positions in the check control register
  localparam int BIT_ABORT      = 7;
  localparam int BIT_DBL_RAMP   = 6;
  localparam int BIT_DBL_SETTLE = 5;
  localparam int BIT_LINE_EN    = 1;
  localparam int BIT_AUTO_SKIP  = 0;

  // Reserved tail of the state readback
  localparam logic [3:0] STATE_READ_TAIL = 4'h5;

  // Channel states, encoded as reported
  typedef enum logic [1:0] {
    ST_PLAY,
    ST_HIZ,
    ST_MUTE,
    ST_DIAG
  } avdr_state_t;

  // One channel's load-check findings
  typedef struct packed {
    logic short_ground;
    logic short_supply;
    logic open_load;
    logic shorted_load;
  } avdr_result_t;

endpackage : avdr_pkg

// ### bench/avdr_load_eng.sv
`timescale 1ns/100ps
// ****************************************
// Load-sensing engine model
// ****************************************
module avdr_load_eng (
  input  wire logic                         clk_i,    // System clock
  input  wire logic                         rst_i,    // Synchronous reset
  input  wire logic [1:0]                   run_i,    // Check running per channel
  input  wire logic [7:0]                   delay_i,  // Cycles until done, at least 2
  input  wire avdr_pkg::avdr_result_t [1:0] find_i,   // Findings to report
  input  wire logic [1:0]                   line_i,   // Line outputs to report
  output logic      [1:0]                   done_o,   // Completion pulse
  output avdr_pkg::avdr_result_t [1:0]      result_o, // Findings, valid with done
  output logic      [1:0]                   line_o    // Line found, valid with done
);
  import avdr_pkg::*;
  logic [1:0][7:0] cnt_q; // Cycles spent checking
  // Count while running; a dropped run (abort) restarts the count
  always_ff @(posedge clk_i) begin
    for (int c = 0; c < 2; c++) begin
      if (rst_i || !run_i[c]) begin
        cnt_q[c]  <= 8'h00;
        done_o[c] <= 1'b0;
      end else begin
        cnt_q[c]  <= (cnt_q[c] == 8'hFF) ? cnt_q[c] : cnt_q[c] + 8'h01;
        done_o[c] <= (cnt_q[c] == delay_i);
      end
    end
  end
  // Outside done the lines carry the inverse, so a stale sample shows up
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      result_o[c] = done_o[c] ? find_i[c] : avdr_result_t'(~find_i[c]);
      line_o[c]   = done_o[c] ? line_i[c] : ~line_i[c];
    end
  end
endmodule : avdr_load_eng

// ### bench/tb_amp_volume_diag_regs.sv
`timescale 1ns/100ps
module tb_amp_volume_diag_regs;
  import avdr_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic                   clk, rst, rwr, rrd, rval, abrt, dramp, dset, lchk;
  logic [7:0]             radr, rwd, rdat, dly;
  logic [1:0]             flt, ldone, lline, lrun, mute, lin;
  logic [3:0]             th1, th2;
  logic [1:0][7:0]        gain;
  avdr_result_t [1:0]     lres, find;
  avdr_state_t [1:0]      st;
  int                     err_total, n_compared;
  // Rows: write flag, offset, write data, expected readback
  logic [24:0] rows [17] = '{
    {1'b0,8'h05,8'h00,8'hCF}, {1'b0,8'h06,8'h00,8'hCF}, {1'b0,8'h09,8'h00,8'h00},
    {1'b0,8'h0A,8'h00,8'h11}, {1'b0,8'h0C,8'h00,8'h00}, {1'b0,8'h0E,8'h00,8'h00},
    {1'b0,8'h0F,8'h00,8'h55}, {1'b0,8'h04,8'h00,8'h55}, {1'b1,8'h05,8'hFF,8'hFF},
    {1'b1,8'h05,8'h06,8'h06}, {1'b1,8'h06,8'h07,8'h07}, {1'b1,8'h0A,8'h90,8'h90},
    {1'b1,8'h09,8'h63,8'h63}, {1'b1,8'h0C,8'hFF,8'h00}, {1'b1,8'h0E,8'hFF,8'h00},
    {1'b1,8'h0F,8'h00,8'h55}, {1'b1,8'h20,8'hAB,8'h00}};
  avdr_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .REG_WR_I(rwr), .REG_RD_I(rrd), .REG_ADDR_I(radr),
    .REG_WDATA_I(rwd), .REG_RDATA_O(rdat), .REG_RVALID_O(rval), .CH_FAULT_I(flt), .LOAD_DONE_I(ldone),
    .LOAD_RESULT_I(lres), .LINE_OUT_FOUND_I(lline), .LOAD_RUN_O(lrun), .LOAD_ABORT_O(abrt),
    .DOUBLE_RAMP_O(dramp), .DOUBLE_SETTLE_O(dset), .LINE_OUT_CHECK_EN_O(lchk),
    .CH1_SHORT_THRESHOLD_O(th1), .CH2_SHORT_THRESHOLD_O(th2), .GAIN_CODE_O(gain), .MUTE_O(mute),
    .STATE_O(st));
  avdr_load_eng eng_u (.clk_i(clk), .rst_i(rst), .run_i(lrun), .delay_i(dly), .find_i(find),
    .line_i(lin), .done_o(ldone), .result_o(lres), .line_o(lline));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch reg 0x%h expected 0x%h seen 0x%h", a, e, g);
    end
  endtask : chk_reg
  task automatic chk_out(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected 0x%h seen 0x%h", nm, e, g);
    end
  endtask : chk_out
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : finish_test
  // Strobes rise and fall at falling edges, high for one cycle per request
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    rwr = 1'b1;
    radr = a;
    rwd = d;
    @(negedge clk);
    rwr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rrd = 1'b1;
    radr = a;
    @(negedge clk);
    rrd = 1'b0;
    chk_out("rvalid", 16'h0001, 16'(rval));
    chk_reg(a, e, rdat);
  endtask : rd
  // Bounded wait on the run flags; running out ends the test
  task automatic wait_run(input logic [1:0] v);
    int k = 0;
    while (lrun !== v && k < 400) begin
      @(negedge clk);
      k++;
    end
    chk_out("load_run", 16'(v), 16'(lrun));
    if (lrun !== v) finish_test();
  endtask : wait_run
  // ****************************************
  // Clock and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst, rwr, rrd, radr, rwd, flt, dly, find, lin} = {1'b1, 2'b00, 16'h0000, 2'b00, 8'h03, 8'hA5, 2'b11};
    err_total = 0;
    n_compared = 0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    foreach (rows[i]) begin
      if (rows[i][24]) wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk_out("gain", 16'h0706, 16'(gain));
    chk_out("mute", 16'h0001, 16'(mute));
    chk_out("thresholds", 16'h0090, 16'({th1, th2}));
    chk_out("ctl", 16'h0007, 16'({dramp, dset, lchk}));
    $display("test table done");
    // Host-requested check on both channels, line detection on
    wr(8'h04, 8'hF5);
    wait_run(2'b11);
    chk_out("state", 16'h000F, 16'({st[0], st[1]}));
    wait_run(2'b00);
    rd(8'h0C, 8'h5A);
    rd(8'h0E, 8'h0C);
    rd(8'h0F, 8'h55);
    // Slow engine, line detection off, new findings replace old
    {dly, find} = {8'h3C, 8'h3C};
    wr(8'h09, 8'h01);
    wr(8'h04, 8'hF5);
    wait_run(2'b11);
    wait_run(2'b00);
    rd(8'h0C, 8'hC3);
    rd(8'h0E, 8'h00);
    $display("test requested checks done");
    // Automatic checks on leaving high impedance and after a fault
    dly = 8'h02;
    wr(8'h09, 8'h00);
    wr(8'h04, 8'h25);
    wait_run(2'b11);
    wait_run(2'b00);
    rd(8'h0F, 8'h25);
    @(negedge clk);
    flt = 2'b01;
    @(negedge clk);
    flt = 2'b00;
    wait_run(2'b01);
    wait_run(2'b00);
    // Skip bit set: a fault starts nothing
    wr(8'h09, 8'h01);
    @(negedge clk);
    flt = 2'b11;
    @(negedge clk);
    flt = 2'b00;
    repeat (4) @(negedge clk);
    chk_out("load_run", 16'h0000, 16'(lrun));
    $display("test automatic checks done");
    // Abort a long check in mid-run
    dly = 8'hC8;
    wr(8'h04, 8'hF5);
    wait_run(2'b11);
    wr(8'h09, 8'h80);
    chk_out("abort", 16'h0001, 16'(abrt));
    wait_run(2'b00);
    rd(8'h09, 8'h00);
    $display("test abort done");
    // Second reset in mid-run, a long check under way
    wr(8'h04, 8'hF5);
    wait_run(2'b11);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk_out("state", 16'h0005, 16'({st[0], st[1]}));
    chk_out("load_run", 16'h0000, 16'(lrun));
    chk_out("gain", 16'hCFCF, 16'(gain));
    rd(8'h0F, 8'h55);
    $display("test reset done");
    finish_test();
  end
endmodule : tb_amp_volume_diag_regs
